// [src/clock_reset_generator_core.sv]
// Register front end and mode logic of the clock and reset generator
//
// Notes on behaviour
// RULE1 - Periodic and watchdog counters run only with nonzero rate values.
// RULE2 - Wait mode gates clocks per wait-disable bits in clock select.
// RULE3 - Stop entry: pseudo-stop select 0 gives full stop, 1 pseudo-stop.
// RULE4 - Full stop: oscillator off, all clocks off, counters frozen.
// RULE5 - Pseudo-stop: oscillator on; counters run only if stop enables set.
// RULE6 - Limp mode entered on clock loss with monitor and limp enables set.
// RULE7 - Limp mode runs quality check and stays until clock passes it.
// RULE8 - Reset pin low initializes the block asynchronously.
// RULE9 - Reset pin driven low open-drain while internal reset is triggered.
// RULE10 - Twelve byte registers at consecutive indices 0x0 to 0xB.
// RULE11 - PLL output is two times oscillator times multiplier plus one.
// RULE12 - Reference divider divides oscillator by its value plus one.
// RULE13 - PLL output never below minimum VCO frequency.
// RULE14 - With PLL selected the bus clock is PLL output over two.
// RULE15 - Multiplier always readable; writes ignored while PLL selected.
// RULE16 - Reference divider always readable; writes ignored while PLL selected.
// RULE17 - Accepted multiplier or divider write clears lock and track.
// RULE18 - Factory test flags read zero and ignore writes.
// RULE19 - Software leaves factory test registers alone.
// RULE20 - Lock change sets sticky flag, write one clears, gated request.
// RULE21 - Limp status change sets sticky flag, write one clears, gated request.
// RULE22 - Lock and track read zero in limp mode.
// RULE23 - Unimplemented bits read zero, writes discarded. Clock select stores and reads back its bit 4.
`timescale 1ns/1ns
module clock_reset_generator_core
   import clock_reset_generator_pkg::*;
#(
   parameter int ADDR_W = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wait_req,
   input wire logic stop_req,
   input wire logic osc_clock_lost,
   input wire logic clock_quality_ok,
   input wire logic pll_lock_in,
   input wire logic pll_track_in,
   input wire logic internal_reset_req,
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe_n,
   output clk_gate_s clk_gate,
   output pll_cfg_s pll_cfg,
   output logic quality_check,
   output logic limp_mode,
   output logic [6:0] periodic_rate,
   output logic [7:0] watchdog_ctl,
   output logic watchdog_service_pulse,
   output logic [7:0] watchdog_service_data,
   output logic lock_irq,
   output logic limp_irq
);
   // =========================================
   // Reset
   // External pin low resets everything except the pin driver
   wire logic core_rst_n = presetn & reset_pin_in; // RULE8

   // =========================================
   // APB decode
   wire logic [3:0] idx = paddr[ADDR_W-1:2];
   wire logic aligned = (paddr[1:0] == 2'b00);
   wire logic mapped = aligned && (idx <= IDX_WATCHDOG_SERVICE); // RULE10
   wire logic setup = psel && !penable;
   wire logic wr = psel && penable && pready && pwrite && mapped;
   wire logic [7:0] wdat = pwdata[7:0];

   logic [7:0] mult_q, refdiv_q, irq_en_q, select_q, pll_ctl_q, rate_q, wdog_q;
   logic lock_q, track_q, lock_change_flag_q, limpif_q;
   mode_e mode_q, mode_d;

   wire logic pll_sel = select_q[SEL_PLL];
   wire logic wr_mult = wr && idx == IDX_PLL_MULTIPLIER && !pll_sel; // RULE15
   wire logic wr_ref = wr && idx == IDX_PLL_REFERENCE_DIVIDER && !pll_sel; // RULE16
   wire logic wr_flag = wr && idx == IDX_CLOCK_STATUS_FLAGS;
   wire logic wr_ien = wr && idx == IDX_CLOCK_IRQ_ENABLE;
   wire logic wr_sel = wr && idx == IDX_CLOCK_SOURCE_SELECT;
   wire logic wr_pctl = wr && idx == IDX_PLL_CONTROL;
   wire logic wr_rate = wr && idx == IDX_PERIODIC_IRQ_RATE;
   wire logic wr_wdog = wr && idx == IDX_WATCHDOG_CONTROL;
   wire logic wr_svc = wr && idx == IDX_WATCHDOG_SERVICE;
   wire logic pll_reinit = wr_mult || wr_ref; // RULE17

   // =========================================
   // Read mux; test registers and service register read zero
   wire logic limp = (mode_q == MODE_LIMP);
   wire logic [7:0] flags = {3'b000, lock_change_flag_q, lock_q, track_q, limpif_q, limp};
   logic [7:0] rmux;
   always_comb begin
      rmux = 8'h00; // RULE18 RULE23
      unique case (idx)
         IDX_PLL_MULTIPLIER: rmux = mult_q;
         IDX_PLL_REFERENCE_DIVIDER: rmux = refdiv_q;
         IDX_CLOCK_STATUS_FLAGS: rmux = flags;
         IDX_CLOCK_IRQ_ENABLE: rmux = irq_en_q;
         IDX_CLOCK_SOURCE_SELECT: rmux = select_q;
         IDX_PLL_CONTROL: rmux = pll_ctl_q;
         IDX_PERIODIC_IRQ_RATE: rmux = rate_q;
         IDX_WATCHDOG_CONTROL: rmux = wdog_q;
         default: rmux = 8'h00;
      endcase
   end

   // No wait state: answer in the first access cycle
   always_ff @(posedge pclk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped;
         if (setup && !pwrite && mapped)
            prdata <= {24'h00_0000, rmux};
      end
   end

   // =========================================
   // Control registers; masks drop unimplemented bits, except clock select, which is stored unmasked
   always_ff @(posedge pclk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         mult_q <= MULT_RESET;
         refdiv_q <= REFDIV_RESET;
         irq_en_q <= IRQ_EN_RESET;
         select_q <= SELECT_RESET;
         pll_ctl_q <= PLL_CTL_RESET;
         rate_q <= RATE_RESET;
         wdog_q <= WDOG_RESET;
      end else begin
         if (wr_mult) mult_q <= wdat & MULT_MASK; // RULE15 RULE23
         if (wr_ref) refdiv_q <= wdat & REFDIV_MASK; // RULE16
         if (wr_ien) irq_en_q <= wdat & IRQ_EN_MASK;
         if (wr_sel) select_q <= wdat;
         if (wr_pctl) pll_ctl_q <= wdat & PLL_CTL_MASK;
         if (wr_rate) rate_q <= wdat & RATE_MASK;
         if (wr_wdog) wdog_q <= wdat & WDOG_MASK;
      end
   end

   // =========================================
   // Lock, track and sticky flags; a set beats a clear
   wire logic lock_d = !limp && !pll_reinit && pll_lock_in; // RULE17 RULE22
   wire logic track_d = !limp && !pll_reinit && pll_track_in; // RULE17 RULE22
   wire logic limp_d = (mode_d == MODE_LIMP);
   wire logic lock_change_flag_set = (lock_d != lock_q); // RULE20
   wire logic limpif_set = (limp_d != limp); // RULE21
   wire logic lock_change_flag_clr = wr_flag && wdat[FLG_LOCK_CHANGE_FLAG];
   wire logic limpif_clr = wr_flag && wdat[FLG_LIMPIF];

   always_ff @(posedge pclk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         lock_q <= 1'b0;
         track_q <= 1'b0;
         lock_change_flag_q <= 1'b0;
         limpif_q <= 1'b0;
      end else begin
         lock_q <= lock_d;
         track_q <= track_d;
         lock_change_flag_q <= lock_change_flag_set || (lock_change_flag_q && !lock_change_flag_clr); // RULE20
         limpif_q <= limpif_set || (limpif_q && !limpif_clr); // RULE21
      end
   end

   // =========================================
   // Mode machine
   wire logic limp_entry = pll_ctl_q[PC_CME] && pll_ctl_q[PC_LIMPE] && osc_clock_lost;
   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         MODE_RUN: begin
            if (limp_entry)
               mode_d = MODE_LIMP; // RULE6
            else if (stop_req)
               mode_d = select_q[SEL_PSTOP] ? MODE_PSEUDO_STOP : MODE_FULL_STOP; // RULE3
            else if (wait_req)
               mode_d = MODE_WAIT;
         end
         MODE_WAIT: begin
            if (limp_entry)
               mode_d = MODE_LIMP; // RULE6
            else if (!wait_req)
               mode_d = MODE_RUN;
         end
         // Oscillator is off, so the monitor is not trusted here
         MODE_FULL_STOP: begin
            if (!stop_req)
               mode_d = MODE_RUN;
         end
         MODE_PSEUDO_STOP: begin
            if (limp_entry)
               mode_d = MODE_LIMP; // RULE6
            else if (!stop_req)
               mode_d = MODE_RUN;
         end
         MODE_LIMP: begin
            if (clock_quality_ok)
               mode_d = MODE_RUN; // RULE7
         end
         default: mode_d = MODE_RUN;
      endcase
   end

   always_ff @(posedge pclk or negedge core_rst_n) begin
      if (!core_rst_n)
         mode_q <= MODE_RUN;
      else
         mode_q <= mode_d;
   end

   // =========================================
   // Clock gating per mode
   wire logic rate_on = (rate_q[6:0] != 7'h00); // RULE1
   wire logic wdog_on = (wdog_q[2:0] != 3'b000); // RULE1
   clk_gate_s gate_d;
   always_comb begin
      gate_d = '{osc: 1'b1, sys: 1'b1, core: 1'b1, pll: pll_ctl_q[PC_PLLON],
                 periodic: rate_on, watchdog: wdog_on};
      unique case (mode_d)
         MODE_RUN: gate_d.pll = pll_ctl_q[PC_PLLON];
         MODE_WAIT: begin
            gate_d.sys = !select_q[SEL_SYSWAI]; // RULE2
            gate_d.core = !select_q[SEL_CWAI]; // RULE2
            gate_d.pll = pll_ctl_q[PC_PLLON] && !select_q[SEL_PLLWAI]; // RULE2
            gate_d.periodic = rate_on && !select_q[SEL_RTIWAI]; // RULE2
            gate_d.watchdog = wdog_on && !select_q[SEL_COPWAI]; // RULE2
         end
         MODE_FULL_STOP: begin
            gate_d = '0; // RULE4
         end
         MODE_PSEUDO_STOP: begin
            gate_d.sys = 1'b0; // RULE5
            gate_d.core = 1'b0;
            gate_d.pll = 1'b0;
            gate_d.periodic = rate_on && pll_ctl_q[PC_PRE]; // RULE5
            gate_d.watchdog = wdog_on && pll_ctl_q[PC_PCE]; // RULE5
         end
         // Limp mode runs everything from the PLL at its floor
         MODE_LIMP: gate_d.pll = 1'b1;
         default: gate_d = '0;
      endcase
   end

   // =========================================
   // PLL settings: ratio is mult_num over ref_den
   pll_cfg_s cfg_d;
   always_comb begin
      cfg_d.mult_num = {mult_q[6:0] + 7'd1, 1'b0}; // RULE11
      cfg_d.ref_den = {1'b0, refdiv_q[3:0]} + 5'd1; // RULE12
      cfg_d.pll_on = pll_ctl_q[PC_PLLON] || limp_d;
      cfg_d.bus_div2 = pll_sel; // RULE14
      cfg_d.floor_min = 1'b1; // RULE13
   end

   always_ff @(posedge pclk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         clk_gate <= '0;
         pll_cfg <= '0;
         quality_check <= 1'b0;
         limp_mode <= 1'b0;
         periodic_rate <= 7'h00;
         watchdog_ctl <= 8'h00;
         watchdog_service_pulse <= 1'b0;
         watchdog_service_data <= 8'h00;
         lock_irq <= 1'b0;
         limp_irq <= 1'b0;
      end else begin
         clk_gate <= gate_d;
         pll_cfg <= cfg_d;
         quality_check <= limp_d; // RULE7
         limp_mode <= limp_d;
         periodic_rate <= rate_q[6:0];
         watchdog_ctl <= wdog_q;
         watchdog_service_pulse <= wr_svc;
         if (wr_svc) watchdog_service_data <= wdat;
         lock_irq <= lock_change_flag_q && irq_en_q[FLG_LOCK_CHANGE_FLAG]; // RULE20
         limp_irq <= limpif_q && irq_en_q[FLG_LIMPIF]; // RULE21
      end
   end

   // =========================================
   // Reset pin driver
   // Reset by presetn only: a pin reset here would release its own drive
   logic [7:0] drive_cnt_q;
   wire logic drive_busy = (drive_cnt_q != 8'h00);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_cnt_q <= 8'h00;
         reset_pin_out <= 1'b0;
         reset_pin_oe_n <= 1'b1;
      end else begin
         if (internal_reset_req)
            drive_cnt_q <= 8'(RESET_DRIVE_CYC); // RULE9
         else if (drive_busy)
            drive_cnt_q <= drive_cnt_q - 8'h01;
         reset_pin_out <= 1'b0;
         reset_pin_oe_n <= !(internal_reset_req || drive_cnt_q > 8'h01); // RULE9
      end
   end

   // =========================================
   // Checks
   sequence s_stop_seen;
      mode_q == MODE_RUN && stop_req && !limp_entry;
   endsequence

   property p_stop_select;
      @(posedge pclk) disable iff (!core_rst_n)
      s_stop_seen |=>
         mode_q == ($past(select_q[SEL_PSTOP]) ? MODE_PSEUDO_STOP : MODE_FULL_STOP);
   endproperty
   a_stop_select: assert property (p_stop_select) else $error("wrong stop mode"); // RULE3
   // Gates come from the next mode, so they line up with mode_q
   property p_full_stop;
      @(posedge pclk) disable iff (!core_rst_n)
      mode_q == MODE_FULL_STOP |-> clk_gate == '0;
   endproperty
   a_full_stop: assert property (p_full_stop) else $error("clock alive in full stop"); // RULE4
   property p_pseudo;
      @(posedge pclk) disable iff (!core_rst_n)
      mode_q == MODE_PSEUDO_STOP && !$past(pll_ctl_q[PC_PCE]) |->
         !clk_gate.watchdog && !clk_gate.core && clk_gate.osc;
   endproperty
   a_pseudo: assert property (p_pseudo) else $error("pseudo-stop gating wrong"); // RULE5
   property p_wait_gate;
      @(posedge pclk) disable iff (!core_rst_n)
      mode_d == MODE_WAIT |=> clk_gate.sys == !$past(select_q[SEL_SYSWAI])
         && clk_gate.core == !$past(select_q[SEL_CWAI]);
   endproperty
   a_wait_gate: assert property (p_wait_gate) else $error("wait gating wrong"); // RULE2
   property p_limp_entry;
      @(posedge pclk) disable iff (!core_rst_n)
      mode_q == MODE_LIMP && !$past(limp) |->
         $past(pll_ctl_q[PC_CME] && pll_ctl_q[PC_LIMPE] && osc_clock_lost);
   endproperty
   a_limp_entry: assert property (p_limp_entry) else $error("limp entry without cause"); // RULE6
   property p_limp_exit;
      @(posedge pclk) disable iff (!core_rst_n)
      limp && !clock_quality_ok |=> limp && quality_check;
   endproperty
   a_limp_exit: assert property (p_limp_exit) else $error("limp left early"); // RULE7
   property p_limp_lock;
      @(posedge pclk) disable iff (!core_rst_n)
      limp |=> !lock_q && !track_q;
   endproperty
   a_limp_lock: assert property (p_limp_lock) else $error("lock set in limp"); // RULE22
   property p_mult_locked;
      @(posedge pclk) disable iff (!core_rst_n)
      pll_sel |=> $stable(mult_q) && $stable(refdiv_q);
   endproperty
   a_mult_locked: assert property (p_mult_locked) else $error("divider written"); // RULE15 RULE16
   property p_reinit;
      @(posedge pclk) disable iff (!core_rst_n)
      pll_reinit |=> !lock_q && !track_q && (lock_change_flag_q || !$past(lock_q));
   endproperty
   a_reinit: assert property (p_reinit) else $error("lock not reinitialized"); // RULE17
   property p_test_zero;
      @(posedge pclk) disable iff (!core_rst_n)
      setup && !pwrite && idx == IDX_FACTORY_TEST_FLAGS && aligned |=> prdata == 32'h0;
   endproperty
   a_test_zero: assert property (p_test_zero) else $error("test flags nonzero"); // RULE18
   property p_lock_change_flag;
      @(posedge pclk) disable iff (!core_rst_n)
      $changed(lock_q) |-> lock_change_flag_q;
   endproperty
   a_lock_change_flag: assert property (p_lock_change_flag) else $error("lock change missed"); // RULE20
   property p_limpif;
      @(posedge pclk) disable iff (!core_rst_n)
      $changed(limp) |-> limpif_q ##1 limp_irq == $past(irq_en_q[FLG_LIMPIF]);
   endproperty
   a_limpif: assert property (p_limpif) else $error("limp change missed"); // RULE21
   property p_pin_drive;
      @(posedge pclk) disable iff (!presetn)
      internal_reset_req |=> !reset_pin_oe_n [*8];
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("reset pin not driven"); // RULE9
   property p_bus_div;
      @(posedge pclk) disable iff (!core_rst_n)
      pll_sel |=> pll_cfg.bus_div2 && pll_cfg.floor_min;
   endproperty
   a_bus_div: assert property (p_bus_div) else $error("bus clock not halved"); // RULE14 RULE13
   property p_ratio;
      @(posedge pclk) disable iff (!core_rst_n)
      1'b1 |=> pll_cfg.mult_num == {$past(mult_q[6:0]) + 7'd1, 1'b0}
         && pll_cfg.ref_den == $past(refdiv_q[3:0]) + 5'd1;
   endproperty
   a_ratio: assert property (p_ratio) else $error("PLL ratio wrong"); // RULE11 RULE12
endmodule

// [src/clock_reset_generator_pkg.sv]
// Constants, types and register map of the clock and reset generator core
package clock_reset_generator_pkg;
   // =========================================
   // Register indices; byte address is four times the index
   localparam logic [3:0] IDX_PLL_MULTIPLIER = 4'h0;
   localparam logic [3:0] IDX_PLL_REFERENCE_DIVIDER = 4'h1;
   localparam logic [3:0] IDX_FACTORY_TEST_FLAGS = 4'h2;
   localparam logic [3:0] IDX_CLOCK_STATUS_FLAGS = 4'h3;
   localparam logic [3:0] IDX_CLOCK_IRQ_ENABLE = 4'h4;
   localparam logic [3:0] IDX_CLOCK_SOURCE_SELECT = 4'h5;
   localparam logic [3:0] IDX_PLL_CONTROL = 4'h6;
   localparam logic [3:0] IDX_PERIODIC_IRQ_RATE = 4'h7;
   localparam logic [3:0] IDX_WATCHDOG_CONTROL = 4'h8;
   localparam logic [3:0] IDX_FACTORY_FORCE_BYPASS = 4'h9;
   localparam logic [3:0] IDX_FACTORY_TEST_CONTROL = 4'hA;
   localparam logic [3:0] IDX_WATCHDOG_SERVICE = 4'hB;
   // =========================================
   // Field positions
   localparam int FLG_LOCK_CHANGE_FLAG = 4;
   localparam int FLG_LOCK = 3;
   localparam int FLG_TRACK = 2;
   localparam int FLG_LIMPIF = 1;
   localparam int FLG_LIMP = 0;
   localparam int SEL_PLL = 7;
   localparam int SEL_PSTOP = 6;
   localparam int SEL_SYSWAI = 5;
   localparam int SEL_PLLWAI = 3;
   localparam int SEL_CWAI = 2;
   localparam int SEL_RTIWAI = 1;
   localparam int SEL_COPWAI = 0;
   localparam int PC_CME = 7;
   localparam int PC_PLLON = 6;
   localparam int PC_PRE = 2;
   localparam int PC_PCE = 1;
   localparam int PC_LIMPE = 0;
   // =========================================
   // Writable masks and values after reset
   localparam logic [7:0] MULT_MASK = 8'h3F;
   localparam logic [7:0] REFDIV_MASK = 8'h0F;
   localparam logic [7:0] FLAG_W1C_MASK = 8'h12;
   localparam logic [7:0] IRQ_EN_MASK = 8'h12;
   localparam logic [7:0] PLL_CTL_MASK = 8'hF7;
   localparam logic [7:0] RATE_MASK = 8'h7F;
   localparam logic [7:0] WDOG_MASK = 8'hC7;
   localparam logic [7:0] MULT_RESET = 8'h00;
   localparam logic [7:0] REFDIV_RESET = 8'h00;
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;
   localparam logic [7:0] SELECT_RESET = 8'h00;
   localparam logic [7:0] PLL_CTL_RESET = 8'h00;
   localparam logic [7:0] RATE_RESET = 8'h00;
   localparam logic [7:0] WDOG_RESET = 8'h00;
   // =========================================
   // Timing: reset pin drive time at a 100 ns clock
   localparam int CLK_PERIOD_NS = 100;
   localparam int RESET_DRIVE_NS = 1600;
   localparam int RESET_DRIVE_CYC = (RESET_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // =========================================
   typedef enum logic [2:0] {
      MODE_RUN, MODE_WAIT, MODE_FULL_STOP, MODE_PSEUDO_STOP, MODE_LIMP
   } mode_e;
   typedef struct packed {
      logic osc;
      logic sys;
      logic core;
      logic pll;
      logic periodic;
      logic watchdog;
   } clk_gate_s;
   typedef struct packed {
      logic [7:0] mult_num;
      logic [4:0] ref_den;
      logic pll_on;
      logic bus_div2;
      logic floor_min;
   } pll_cfg_s;
endpackage

// [tb/clock_far_side.sv]
// Model of oscillator monitor, PLL analog and the pulled-up reset pin
`timescale 1ns/1ns
module clock_far_side (
   input wire logic pclk,
   input wire logic osc_kill,
   input wire logic lock_want,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe_n,
   output logic osc_clock_lost,
   output logic clock_quality_ok,
   output logic pll_lock_in,
   output logic pll_track_in,
   output logic reset_pin_in
);
   // =========================================
   // Clock monitor and quality check
   logic [3:0] good_cnt_q = 4'h0;
   assign osc_clock_lost = osc_kill;
   // Quality passes only after eight clean cycles, so limp mode must linger
   assign clock_quality_ok = good_cnt_q[3];
   always @(posedge pclk) begin
      good_cnt_q <= osc_kill ? 4'h0 : (good_cnt_q[3] ? good_cnt_q : good_cnt_q + 4'h1);
   end
   // =========================================
   // PLL lock and track follow the request a cycle late
   assign pll_track_in = pll_lock_in;
   always @(posedge pclk) begin
      pll_lock_in <= lock_want;
   end
   // =========================================
   // Open-drain pin with pull-up; low only while the core drives it
   assign reset_pin_in = reset_pin_oe_n ? 1'b1 : reset_pin_out;
endmodule

// [tb/clock_reset_generator_core_bench.sv]
// Self-checking bench of the clock and reset generator core
`timescale 1ns/1ns
module clock_reset_generator_core_bench;
   import clock_reset_generator_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, wait_req, stop_req, internal_reset_req;
   logic osc_kill, lock_want;
   logic [5:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, lost, qok, lock_in, track_in, pin_in, pin_out, oe_n;
   logic quality_check, limp_mode, lock_irq, limp_irq;
   logic svc_pulse;
   logic [6:0] rate_out;
   logic [7:0] wdog_out, svc_data;
   clk_gate_s gate;
   pll_cfg_s cfg;
   int n_errors = 0;
   int checks_done = 0;
   clock_reset_generator_core u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .wait_req(wait_req), .stop_req(stop_req),
      .osc_clock_lost(lost), .clock_quality_ok(qok), .pll_lock_in(lock_in),
      .pll_track_in(track_in), .internal_reset_req(internal_reset_req),
      .reset_pin_in(pin_in), .reset_pin_out(pin_out), .reset_pin_oe_n(oe_n),
      .clk_gate(gate), .pll_cfg(cfg), .quality_check(quality_check),
      .limp_mode(limp_mode), .periodic_rate(rate_out), .watchdog_ctl(wdog_out),
      .watchdog_service_pulse(svc_pulse), .watchdog_service_data(svc_data), .lock_irq(lock_irq),
      .limp_irq(limp_irq));
   clock_far_side u_far (.pclk(pclk), .osc_kill(osc_kill), .lock_want(lock_want),
      .reset_pin_out(pin_out), .reset_pin_oe_n(oe_n), .osc_clock_lost(lost),
      .clock_quality_ok(qok), .pll_lock_in(lock_in), .pll_track_in(track_in),
      .reset_pin_in(pin_in));
   // =========================================
   // Clock and watchdog
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      #300000;
      n_errors++;
      wrap_up();
   end
   // =========================================
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic [3:0] idx, input logic w, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= {idx, 2'b00};
      pwrite <= w;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the slave; only the watchdog ends a hang
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
      apb(idx, 1'b0, 8'h00);
      chk(rd, {24'h0, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic wrap_up();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // =========================================
   // Test sequence
   initial begin
      {presetn, psel, penable, pwrite, wait_req, stop_req, internal_reset_req} = 7'h00;
      {osc_kill, lock_want, paddr, pwdata} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 12; i++) rd_chk(4'(i), 8'h00);
      apb(4'hC, 1'b0, 8'h00);
      chk(32'(err), 32'h1);
      apb(4'hB, 1'b1, 8'h5A);
      @(negedge pclk);
      chk(32'({svc_pulse, svc_data}), 32'h15A);
      apb(4'h0, 1'b1, 8'hFF);
      rd_chk(4'h0, 8'h3F);
      chk(32'(cfg.mult_num), 32'h80);
      apb(4'h1, 1'b1, 8'hFF);
      rd_chk(4'h1, 8'h0F);
      chk(32'(cfg.ref_den), 32'h10);
      apb(4'h2, 1'b1, 8'hFF);
      rd_chk(4'h2, 8'h00);
      rd_chk(4'h9, 8'h00);
      rd_chk(4'hA, 8'h00);
      lock_want <= 1'b1;
      cyc(3);
      rd_chk(4'h3, 8'h1C);
      apb(4'h4, 1'b1, 8'h12);
      cyc(2);
      chk(32'(lock_irq), 32'h1);
      apb(4'h3, 1'b1, 8'h00);
      rd_chk(4'h3, 8'h1C);
      apb(4'h3, 1'b1, 8'h10);
      rd_chk(4'h3, 8'h0C);
      apb(4'h5, 1'b1, 8'h80);
      apb(4'h0, 1'b1, 8'h05);
      rd_chk(4'h0, 8'h3F);
      apb(4'h1, 1'b1, 8'h03);
      rd_chk(4'h1, 8'h0F);
      chk(32'(cfg.bus_div2), 32'h1);
      apb(4'h5, 1'b1, 8'h20);
      apb(4'h7, 1'b1, 8'h01);
      apb(4'h8, 1'b1, 8'hFF);
      wait_req <= 1'b1;
      cyc(2);
      chk(32'({gate.sys, gate.core}), 32'h1);
      chk(32'(rate_out), 32'h01);
      chk(32'(wdog_out), 32'hC7);
      @(posedge pclk);
      wait_req <= 1'b0;
      apb(4'h5, 1'b1, 8'h00);
      stop_req <= 1'b1;
      cyc(2);
      chk(32'({gate.osc, gate.sys, gate.core, gate.periodic, gate.watchdog}), 32'h0);
      @(posedge pclk);
      stop_req <= 1'b0;
      cyc(2);
      chk(32'(gate.periodic), 32'h1);
      apb(4'h5, 1'b1, 8'h40);
      apb(4'h6, 1'b1, 8'h04);
      stop_req <= 1'b1;
      cyc(2);
      chk(32'({gate.osc, gate.sys, gate.periodic, gate.watchdog}), 32'hA);
      @(posedge pclk);
      stop_req <= 1'b0;
      apb(4'h6, 1'b1, 8'h81);
      osc_kill <= 1'b1;
      cyc(3);
      chk(32'({limp_mode, quality_check, cfg.pll_on, gate.pll}), 32'hF);
      chk(32'(limp_irq), 32'h1);
      apb(4'h3, 1'b0, 8'h00);
      chk(rd & 32'h0F, 32'h03);
      osc_kill <= 1'b0;
      cyc(3);
      chk(32'(limp_mode), 32'h1);
      cyc(12);
      chk(32'(limp_mode), 32'h0);
      @(posedge pclk);
      internal_reset_req <= 1'b1;
      @(posedge pclk);
      internal_reset_req <= 1'b0;
      cyc(1);
      chk(32'({oe_n, pin_out}), 32'h0);
      for (int i = 0; i < 40 && oe_n !== 1'b1; i++) @(posedge pclk);
      chk(32'(oe_n), 32'h1);
      cyc(2);
      rd_chk(4'h0, 8'h00);
      rd_chk(4'h5, 8'h00);
      wrap_up();
   end
endmodule
